// file: design/rim_pkg.sv
package rim_pkg;

  localparam logic [7:0] RIM_OFS_EN_A = 8'h02;
  localparam logic [7:0] RIM_OFS_EN_B = 8'h03;
  localparam logic [7:0] RIM_OFS_EN_C = 8'h04;
  localparam logic [7:0] RIM_OFS_FL_A = 8'h05;
  localparam logic [7:0] RIM_OFS_FL_B = 8'h06;
  localparam logic [7:0] RIM_OFS_FL_C = 8'h07;
  localparam logic [7:0] RIM_OFS_CMD = 8'h0f;
  localparam logic [7:0] RIM_CMD_SOFT_RESET = 8'hff;

  localparam logic [7:0] RIM_EN_RST = 8'h00;
  localparam logic [7:0] RIM_FL_RST = 8'h00;
  localparam logic [7:0] RIM_RDATA_RST = 8'h00;

  // Implemented bits per group; the rest are reserved or unused and read zero.
  localparam logic [7:0] RIM_VALID_A = 8'hff;
  localparam logic [7:0] RIM_VALID_B = 8'hbf;
  localparam logic [7:0] RIM_VALID_C = 8'hfc;

  // Bit positions of the role-qualified retry failures in group a.
  localparam int RIM_BIT_ACK_FAIL = 3;
  localparam int RIM_BIT_DATA_FAIL = 2;

  typedef struct packed {
    logic tx_buf1_sent;
    logic tx_buf0_sent;
    logic rx_buf1_stored;
    logic rx_buf0_stored;
    logic ack_retry_failed;
    logic data_retry_failed;
    logic pair_wake_done;
    logic pair_wake_failed;
  } rim_evt_a_s;

  typedef struct packed {
    logic battery_threshold_flag;
    logic reserved6;
    logic sync_lost;
    logic paired_full;
    logic already_paired;
    logic tx_ctrl_ready;
    logic rx_ctrl_ready;
    logic known_peer_seen;
  } rim_evt_b_s;

  typedef struct packed {
    logic temp_pair_done;
    logic temp_pair_failed;
    logic raw_rx_done;
    logic raw_tx_done;
    logic end_comm_req;
    logic unpair_req;
    logic [1:0] unused;
  } rim_evt_c_s;

  typedef struct packed {
    rim_evt_a_s a;
    rim_evt_b_s b;
    rim_evt_c_s c;
  } rim_evt_s;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rim_req_s;

  typedef struct packed {
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] en_c;
    logic [7:0] fl_a;
    logic [7:0] fl_b;
    logic [7:0] fl_c;
    logic [7:0] rdata;
    logic rvld;
    logic irq;
  } rim_state_s;

endpackage

// file: design/rim_irq_unit.sv
`timescale 1ns/1ps
`default_nettype none
module rim_irq_unit
  import rim_pkg::*;
(
  input wire logic sys_clk, // 200 MHz register clock
  input wire logic rst_b, // synchronous reset, active low
  input wire rim_req_s req, // register access from serial interface
  output logic [7:0] reg_rdata, // read data, one cycle after read
  output logic reg_rdata_vld, // read data valid pulse
  input wire rim_evt_s evt, // event pulses from link manager
  input wire logic master_role, // high when configured as master
  output logic irq_out // interrupt pin, active high
);

  rim_state_s q_ff;
  rim_state_s nxt_q;
  rim_evt_s set;
  logic soft_rst;

  function automatic logic [7:0] upd_flags(input logic [7:0] cur, input logic clr,
                                           input logic [7:0] sv, input logic [7:0] valid);
    upd_flags = ((clr ? RIM_FL_RST : cur) | sv) & valid;
  endfunction

  always_comb
  begin
    nxt_q = q_ff;
    set = evt;
    set.a.ack_retry_failed = evt.a.ack_retry_failed & ~master_role;
    set.a.data_retry_failed = evt.a.data_retry_failed & master_role;
    soft_rst = req.wr && req.addr == RIM_OFS_CMD && req.wdata == RIM_CMD_SOFT_RESET;
    nxt_q.rvld = req.rd;
    nxt_q.rdata = RIM_RDATA_RST;
    if (req.rd)
    begin
      case (req.addr)
        RIM_OFS_EN_A: nxt_q.rdata = q_ff.en_a;
        RIM_OFS_EN_B: nxt_q.rdata = q_ff.en_b;
        RIM_OFS_EN_C: nxt_q.rdata = q_ff.en_c;
        RIM_OFS_FL_A: nxt_q.rdata = q_ff.fl_a;
        RIM_OFS_FL_B: nxt_q.rdata = q_ff.fl_b;
        RIM_OFS_FL_C: nxt_q.rdata = q_ff.fl_c;
        default: nxt_q.rdata = RIM_RDATA_RST;
      endcase
    end
    if (req.wr && req.addr == RIM_OFS_EN_A)
    begin
      nxt_q.en_a = req.wdata & RIM_VALID_A;
    end
    if (req.wr && req.addr == RIM_OFS_EN_B)
    begin
      nxt_q.en_b = req.wdata & RIM_VALID_B;
    end
    if (req.wr && req.addr == RIM_OFS_EN_C)
    begin
      nxt_q.en_c = req.wdata & RIM_VALID_C;
    end
    nxt_q.fl_a = upd_flags(q_ff.fl_a, req.rd && req.addr == RIM_OFS_FL_A, set.a, RIM_VALID_A);
    nxt_q.fl_b = upd_flags(q_ff.fl_b, req.rd && req.addr == RIM_OFS_FL_B, set.b, RIM_VALID_B);
    nxt_q.fl_c = upd_flags(q_ff.fl_c, req.rd && req.addr == RIM_OFS_FL_C, set.c, RIM_VALID_C);
    if (soft_rst)
    begin
      nxt_q.en_a = RIM_EN_RST;
      nxt_q.en_b = RIM_EN_RST;
      nxt_q.en_c = RIM_EN_RST;
      nxt_q.fl_a = upd_flags(RIM_FL_RST, 1'b1, set.a, RIM_VALID_A);
      nxt_q.fl_b = upd_flags(RIM_FL_RST, 1'b1, set.b, RIM_VALID_B);
      nxt_q.fl_c = upd_flags(RIM_FL_RST, 1'b1, set.c, RIM_VALID_C);
    end
    nxt_q.irq = |((nxt_q.fl_a & nxt_q.en_a) | (nxt_q.fl_b & nxt_q.en_b)
                  | (nxt_q.fl_c & nxt_q.en_c));
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      q_ff <= '{en_a: RIM_EN_RST, en_b: RIM_EN_RST, en_c: RIM_EN_RST,
                fl_a: RIM_FL_RST, fl_b: RIM_FL_RST, fl_c: RIM_FL_RST,
                rdata: RIM_RDATA_RST, rvld: 1'b0, irq: 1'b0};
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign reg_rdata = q_ff.rdata;
  assign reg_rdata_vld = q_ff.rvld;
  assign irq_out = q_ff.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_flag_set_masked;
    evt.a.tx_buf1_sent && q_ff.en_a[7] == 1'b0 |=> q_ff.fl_a[7]
      && (!q_ff.irq || ((q_ff.fl_a & q_ff.en_a) | (q_ff.fl_b & q_ff.en_b)
                        | (q_ff.fl_c & q_ff.en_c)) != 8'h00);
  endproperty
  a_flag_set_masked: assert property (p_flag_set_masked)
    else $error("flag not set while enable bit low");

  property p_irq_blocked;
    ((q_ff.fl_a & q_ff.en_a) | (q_ff.fl_b & q_ff.en_b) | (q_ff.fl_c & q_ff.en_c)) == 8'h00
      |-> !irq_out;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked)
    else $error("interrupt high with no enabled flag");

  property p_irq_follows;
    irq_out == |((q_ff.fl_a & q_ff.en_a) | (q_ff.fl_b & q_ff.en_b) | (q_ff.fl_c & q_ff.en_c));
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt does not match enabled flags");

  property p_reserved_zero;
    q_ff.en_b[6] == 1'b0 && q_ff.en_c[1:0] == 2'b00 && q_ff.fl_b[6] == 1'b0
      && q_ff.fl_c[1:0] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");

  property p_read_clears;
    req.rd && req.addr == RIM_OFS_FL_A && evt.a == 8'h00 && evt.b == 8'h00
      |=> q_ff.fl_a == 8'h00 && q_ff.rvld && q_ff.rdata == $past(q_ff.fl_a)
          && (q_ff.fl_b == $past(q_ff.fl_b) || $past(soft_rst));
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("flag read did not return and clear");

  property p_rx_stored;
    evt.a.rx_buf0_stored |=> q_ff.fl_a[4];
  endproperty
  a_rx_stored: assert property (p_rx_stored)
    else $error("receive stored flag missing");

  property p_client_ack_fail;
    !master_role && evt.a.ack_retry_failed |=> q_ff.fl_a[RIM_BIT_ACK_FAIL];
  endproperty
  a_client_ack_fail: assert property (p_client_ack_fail)
    else $error("client retry failure not flagged");

  property p_master_no_ack_fail;
    master_role && !q_ff.fl_a[RIM_BIT_ACK_FAIL] |=> !q_ff.fl_a[RIM_BIT_ACK_FAIL];
  endproperty
  a_master_no_ack_fail: assert property (p_master_no_ack_fail)
    else $error("client-only flag set in master role");

  property p_battery;
    evt.b.battery_threshold_flag |=> q_ff.fl_b[7];
  endproperty
  a_battery: assert property (p_battery)
    else $error("battery flag missing");

  property p_soft_reset;
    soft_rst && evt == '0 |=> q_ff.en_a == RIM_EN_RST && q_ff.en_b == RIM_EN_RST
      && q_ff.en_c == RIM_EN_RST && q_ff.fl_a == RIM_FL_RST && q_ff.fl_b == RIM_FL_RST
      && q_ff.fl_c == RIM_FL_RST && !irq_out;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore defaults");

  property p_set_wins;
    req.rd && req.addr == RIM_OFS_FL_C && evt.c.unpair_req |=> q_ff.fl_c[2];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost during clearing read");

  property p_tx_sent;
    evt.a[7:6] != 2'b00 |=> (q_ff.fl_a[7:6] & $past(evt.a[7:6])) == $past(evt.a[7:6]);
  endproperty
  a_tx_sent: assert property (p_tx_sent)
    else $error("transmit sent flag missing");

  property p_client_no_data_fail;
    !master_role && !q_ff.fl_a[RIM_BIT_DATA_FAIL] |=> !q_ff.fl_a[RIM_BIT_DATA_FAIL];
  endproperty
  a_client_no_data_fail: assert property (p_client_no_data_fail)
    else $error("master-only flag set in client role");

  property p_master_data_fail;
    master_role && evt.a.data_retry_failed |=> q_ff.fl_a[RIM_BIT_DATA_FAIL];
  endproperty
  a_master_data_fail: assert property (p_master_data_fail)
    else $error("master retry failure not flagged");

  property p_pair_wake;
    evt.a[1:0] != 2'b00 |=> (q_ff.fl_a[1:0] & $past(evt.a[1:0])) == $past(evt.a[1:0]);
  endproperty
  a_pair_wake: assert property (p_pair_wake)
    else $error("pair or wake result flag missing");

  property p_sync_lost;
    evt.b.sync_lost |=> q_ff.fl_b[5];
  endproperty
  a_sync_lost: assert property (p_sync_lost)
    else $error("sync lost flag missing");

  property p_paired_full;
    evt.b.paired_full |=> q_ff.fl_b[4];
  endproperty
  a_paired_full: assert property (p_paired_full)
    else $error("pairing full flag missing");

  property p_already_paired;
    evt.b.already_paired |=> q_ff.fl_b[3];
  endproperty
  a_already_paired: assert property (p_already_paired)
    else $error("already paired flag missing");

  property p_ctrl_ready;
    evt.b[2:1] != 2'b00 |=> (q_ff.fl_b[2:1] & $past(evt.b[2:1])) == $past(evt.b[2:1]);
  endproperty
  a_ctrl_ready: assert property (p_ctrl_ready)
    else $error("controller ready flag missing");

  property p_known_peer;
    evt.b.known_peer_seen |=> q_ff.fl_b[0];
  endproperty
  a_known_peer: assert property (p_known_peer)
    else $error("known peer flag missing");

  property p_temp_pair;
    evt.c[7:6] != 2'b00 |=> (q_ff.fl_c[7:6] & $past(evt.c[7:6])) == $past(evt.c[7:6]);
  endproperty
  a_temp_pair: assert property (p_temp_pair)
    else $error("temporary pairing flag missing");

  property p_raw_done;
    evt.c[5:4] != 2'b00 |=> (q_ff.fl_c[5:4] & $past(evt.c[5:4])) == $past(evt.c[5:4]);
  endproperty
  a_raw_done: assert property (p_raw_done)
    else $error("raw mode flag missing");

  property p_end_comm;
    evt.c.end_comm_req |=> q_ff.fl_c[3];
  endproperty
  a_end_comm: assert property (p_end_comm)
    else $error("end of communication flag missing");

  property p_unpair;
    evt.c.unpair_req |=> q_ff.fl_c[2];
  endproperty
  a_unpair: assert property (p_unpair)
    else $error("unpair flag missing");

  property p_read_clears_b;
    req.rd && req.addr == RIM_OFS_FL_B && evt.b == 8'h00 && evt.c == 8'h00
      |=> q_ff.fl_b == 8'h00 && q_ff.rdata == $past(q_ff.fl_b) && q_ff.fl_c == $past(q_ff.fl_c);
  endproperty
  a_read_clears_b: assert property (p_read_clears_b)
    else $error("group b read did not return and clear");

  property p_read_clears_c;
    req.rd && req.addr == RIM_OFS_FL_C && evt.c == 8'h00 && evt.a == 8'h00
      |=> q_ff.fl_c == 8'h00 && q_ff.rdata == $past(q_ff.fl_c) && q_ff.fl_a == $past(q_ff.fl_a);
  endproperty
  a_read_clears_c: assert property (p_read_clears_c)
    else $error("group c read did not return and clear");

  property p_soft_keeps_event;
    soft_rst && evt.a.pair_wake_done |=> q_ff.fl_a[1];
  endproperty
  a_soft_keeps_event: assert property (p_soft_keeps_event)
    else $error("event lost during soft reset");

  property p_en_write;
    req.wr && req.addr == RIM_OFS_EN_C |=> q_ff.en_c == ($past(req.wdata) & RIM_VALID_C);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable write not stored with unused bits cleared");

  // Main scenarios that the bench should reach.
  c_irq_raise: cover property (!irq_out ##1 irq_out);
  c_irq_drop_by_read: cover property (irq_out && req.rd ##1 !irq_out);
  c_set_during_read: cover property (req.rd && req.addr == RIM_OFS_FL_B && evt.b != 8'h00);
  c_soft_reset: cover property (soft_rst && irq_out);
  c_client_ack_fail: cover property (!master_role && evt.a.ack_retry_failed);

endmodule
`default_nettype wire

// file: verification/rim_host.sv
`timescale 1ns/1ps
`default_nettype none
module rim_host
  import rim_pkg::*;
(
  input wire logic sys_clk, // register clock
  output var rim_req_s req, // register access toward the unit
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rdata_vld // read data valid pulse
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge sys_clk);
    req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  // Missing valid turns the returned byte unknown so any compare fails.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge sys_clk);
    req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
    d = reg_rdata_vld ? reg_rdata : 8'hxx;
  endtask
  task automatic service(output logic [23:0] f);
    rd(RIM_OFS_FL_A, f[23:16]);
    rd(RIM_OFS_FL_B, f[15:8]);
    rd(RIM_OFS_FL_C, f[7:0]);
  endtask
endmodule
`default_nettype wire

// file: verification/radio_irq_mask_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module radio_irq_mask_status_bench;
  import rim_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic master_role = 1'b1;
  rim_evt_s evt = '0;
  rim_req_s req;
  logic [7:0] reg_rdata;
  logic reg_rdata_vld;
  logic irq_out;
  logic [23:0] f;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  rim_irq_unit rim_irq_unit_i (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
    .reg_rdata(reg_rdata), .reg_rdata_vld(reg_rdata_vld), .evt(evt),
    .master_role(master_role), .irq_out(irq_out));
  rim_host rim_host_i (.sys_clk(sys_clk), .req(req), .reg_rdata(reg_rdata),
    .reg_rdata_vld(reg_rdata_vld));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rim_host_i.rd(a, v);
    chk(v, exp);
  endtask
  task automatic pulse(input logic [23:0] v);
    @(negedge sys_clk);
    evt <= v;
    @(negedge sys_clk);
    evt <= '0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (12) @(negedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 2; a < 9; a++)
      rchk(8'(a), 8'h00);
    $display("test reset done");
    for (int a = 2; a < 5; a++)
      rim_host_i.wr(8'(a), 8'hff);
    rchk(8'h02, 8'hff);
    rchk(8'h03, 8'hbf);
    rchk(8'h04, 8'hfc);
    for (int a = 2; a < 5; a++)
      rim_host_i.wr(8'(a), 8'h00);
    $display("test enables done");
    pulse(24'hffffff);
    chk({7'h00, irq_out}, 8'h00);
    rchk(8'h05, 8'hf7);
    rchk(8'h06, 8'hbf);
    rchk(8'h07, 8'hfc);
    rchk(8'h05, 8'h00);
    master_role <= 1'b0;
    pulse(24'hffffff);
    rim_host_i.service(f);
    chk(f[23:16], 8'hfb);
    chk(f[15:8], 8'hbf);
    chk(f[7:0], 8'hfc);
    $display("test events done");
    rim_host_i.wr(8'h02, 8'h80);
    pulse(24'h800000);
    chk({7'h00, irq_out}, 8'h01);
    pulse(24'h000100);
    rchk(8'h06, 8'h01);
    chk({7'h00, irq_out}, 8'h01);
    rchk(8'h05, 8'h80);
    chk({7'h00, irq_out}, 8'h00);
    fork
      pulse(24'h400000);
      rchk(8'h05, 8'h00);
    join
    rchk(8'h05, 8'h40);
    $display("test routing done");
    rim_host_i.wr(8'h03, 8'hff);
    pulse(24'h008000);
    chk({7'h00, irq_out}, 8'h01);
    rim_host_i.wr(8'h0f, 8'hff);
    rchk(8'h03, 8'h00);
    chk({7'h00, irq_out}, 8'h00);
    rchk(8'h06, 8'h00);
    $display("test soft reset done");
    rim_host_i.wr(RIM_OFS_EN_C, 8'h04);
    rim_host_i.wr(RIM_OFS_CMD, 8'h0c);
    rim_host_i.wr(RIM_OFS_FL_C, 8'hff);
    rchk(RIM_OFS_EN_C, 8'h04);
    rchk(RIM_OFS_FL_C, 8'h00);
    pulse(24'h000004);
    chk({7'h00, irq_out}, 8'h01);
    fork
      pulse(24'h020000);
      rim_host_i.wr(RIM_OFS_CMD, RIM_CMD_SOFT_RESET);
    join
    chk({7'h00, irq_out}, 8'h00);
    rchk(RIM_OFS_FL_A, 8'h02);
    rchk(RIM_OFS_FL_C, 8'h00);
    $display("test commands done");
    end_sim();
  end
endmodule
`default_nettype wire
